//--- hw/gfxa_arbiter.sv
// Shared DRAM bus arbiter: device end of the two-wire graphics handshake.
// Assumes an APB master on pclk, memory-engine status on pclk and the
// graphics request arriving from a pin outside the clock's domain.
//
// How it works
// - Handshake driven and sampled on host clock.
// - Device owns DRAM unless graphics is granted.
// - Default settings grant high priority within 400ns.
// - Low priority granted only with nothing pending.
// - Timer caps non-graphics cycles after high request.
// - PCI reads release on prefetch full or timeout.
// - Single writes release on timeout or empty buffers.
// - Timer governs PCI reads, single writes, CPU writes.
// - Burst writes break at lines during high request.
// - Timer starts on high request during governed cycles.
// - Timer settings zero to twenty-eight in fours.
// - Defaults twelve for writes, sixteen for reads.
// - Programmable target-ready delay before PCI disconnect.
// - Enabled shared buffer borrows fourth PCI pair.
// - Only current owner drives DRAM lines.
//
// A high-priority request is a request line that, once low, goes high
// for exactly one clock and low again; a plain low level is low priority.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
module gfxa_arbiter
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        gfx_mem_request_n,
  output logic             gfx_mem_grant_n,
  output logic             pci_req_four_n,
  input  wire logic        pci_gnt_four_n,
  input  wire logic        cpu_req_pending,
  input  wire logic        pci_req_pending,
  input  wire logic        refresh_hi_pending,
  input  wire logic        dram_busy,
  input  wire logic        pci_read_active,
  input  wire logic        pci_single_write_active,
  input  wire logic        cpu_single_write_active,
  input  wire logic        burst_write_active,
  input  wire logic        prefetch_full,
  input  wire logic        write_buf_empty,
  input  wire logic        write_cycle_done,
  input  wire logic        pci_trdy_waiting,
  output logic             dram_drive_en,
  output logic             burst_break,
  output logic             pci_disconnect
);

  // Request pin synchroniser; s1 feeds s2 only
  logic req_s1_n;
  logic req_s2_n;
  logic req_act;          // Request asserted, clock domain side

  // Settings and sticky status
  logic                       shared_buffer_control_q;
  logic                       shared_buffer_control_d;
  logic [gfxa_pkg::SET_W-1:0] wlat_q;
  logic [gfxa_pkg::SET_W-1:0] wlat_d;
  logic [gfxa_pkg::SET_W-1:0] rlat_q;
  logic [gfxa_pkg::SET_W-1:0] rlat_d;
  logic [gfxa_pkg::SET_W-1:0] trdy_q;
  logic [gfxa_pkg::SET_W-1:0] trdy_d;
  logic                       ovr_q;
  logic                       ovr_d;

  // APB answer registers
  logic [31:0] prdata_d;
  logic        pready_d;
  logic        pslverr_d;
  logic        wr_en;     // Write takes effect this edge
  logic        hit_ctrl;
  logic        hit_stat;

  // Arbiter state
  gfxa_pkg::gfxa_state_t state_q;
  gfxa_pkg::gfxa_state_t state_d;
  logic                  pend_q;   // Request seen since park
  logic                  pend_d;
  logic                  gap_q;    // One-clock gap in the request
  logic                  gap_d;
  logic                  hi_q;     // High priority recognised
  logic                  hi_d;
  logic [gfxa_pkg::WAIT_W-1:0] wait_q;  // Clocks waited at high
  logic [gfxa_pkg::WAIT_W-1:0] wait_d;

  // Registered pin and engine outputs
  logic gnt_n_d;
  logic drive_d;
  logic brk_d;
  logic preq_n_d;
  logic disc_d;

  // Decision terms
  logic governed;
  logic lo_ok;
  logic hi_ok;
  logic lat_load;
  logic lat_run;
  logic lat_expired;
  logic lat_running;
  logic [gfxa_pkg::SET_W-1:0] lat_setting;
  logic trdy_expired;

  // Two flops before anything reads the pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_s1_n <= 1'b1;
      req_s2_n <= 1'b1;
    end
    else
    begin
      req_s1_n <= gfx_mem_request_n;
      req_s2_n <= req_s1_n;
    end
  end

  assign req_act = !req_s2_n;

  // Zero wait states: pready rises in the access phase
  assign wr_en    = psel && penable && pready && pwrite;
  assign hit_ctrl = (paddr == gfxa_pkg::CTRL_OFS);
  assign hit_stat = (paddr == gfxa_pkg::STAT_OFS);

  // APB answer, prepared during the setup cycle
  always_comb
  begin
    prdata_d  = 32'h0000_0000;
    pready_d  = psel && !penable;
    pslverr_d = 1'b0;
    if (psel && !penable)
    begin
      if (hit_ctrl)
      begin
        prdata_d[gfxa_pkg::CTRL_EN_BIT] = shared_buffer_control_q;
        prdata_d[gfxa_pkg::CTRL_WLAT_LO +: gfxa_pkg::SET_W] = wlat_q;
        prdata_d[gfxa_pkg::CTRL_RLAT_LO +: gfxa_pkg::SET_W] = rlat_q;
        prdata_d[gfxa_pkg::CTRL_TRDY_LO +: gfxa_pkg::SET_W] = trdy_q;
      end
      else if (hit_stat)
      begin
        prdata_d[gfxa_pkg::STAT_GNT_BIT] = !gfx_mem_grant_n;
        prdata_d[gfxa_pkg::STAT_HI_BIT]  = hi_q;
        prdata_d[gfxa_pkg::STAT_RUN_BIT] = lat_running;
        prdata_d[gfxa_pkg::STAT_OVR_BIT] = ovr_q;
      end
      else
        pslverr_d = 1'b1;  // Unmapped address
    end
  end

  // Register writes; overrun set wins over its clear
  always_comb
  begin
    shared_buffer_control_d = shared_buffer_control_q;
    wlat_d = wlat_q;
    rlat_d = rlat_q;
    trdy_d = trdy_q;
    ovr_d  = ovr_q;
    if (wr_en && hit_ctrl)
    begin
      shared_buffer_control_d = pwdata[gfxa_pkg::CTRL_EN_BIT];
      wlat_d = pwdata[gfxa_pkg::CTRL_WLAT_LO +: gfxa_pkg::SET_W];
      rlat_d = pwdata[gfxa_pkg::CTRL_RLAT_LO +: gfxa_pkg::SET_W];
      trdy_d = pwdata[gfxa_pkg::CTRL_TRDY_LO +: gfxa_pkg::SET_W];
    end
    if (wr_en && hit_stat && pwdata[gfxa_pkg::STAT_OVR_BIT])
      ovr_d = 1'b0;
    if (state_q == gfxa_pkg::ST_OWN && hi_q
        && wait_q == gfxa_pkg::HI_BUDGET_CYC)
      ovr_d = 1'b1;  // Budget missed
  end

  // Latency timer: governed DRAM traffic only
  assign governed = pci_read_active || pci_single_write_active
                    || cpu_single_write_active;
  // Starts on a sampled high request during governed traffic
  assign lat_run  = hi_q && governed && state_q == gfxa_pkg::ST_OWN;
  // Reloaded once granted or when the request is withdrawn
  assign lat_load = !hi_q || state_q != gfxa_pkg::ST_OWN;
  // Read and write limits differ by default
  assign lat_setting = pci_read_active ? rlat_q : wlat_q;

  gfxa_timer u_lat_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (lat_load),
    .run     (lat_run),
    .setting (lat_setting),
    .expired (lat_expired),
    .running (lat_running)
  );

  // Target-ready wait before disconnect
  gfxa_timer u_trdy_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (!pci_trdy_waiting),
    .run     (pci_trdy_waiting),
    .setting (trdy_q),
    .expired (trdy_expired),
    .running ()
  );

  // Low priority only when the system is quiet
  assign lo_ok = !(cpu_req_pending || pci_req_pending
                   || refresh_hi_pending) && !dram_busy;
  // High priority release points
  assign hi_ok = !dram_busy
    || (pci_read_active && (prefetch_full || lat_expired))
    || ((pci_single_write_active || cpu_single_write_active)
        && ((lat_expired && write_cycle_done) || write_buf_empty));

  // Arbiter next state and priority decode
  always_comb
  begin
    state_d = state_q;
    pend_d  = pend_q;
    gap_d   = gap_q;
    hi_d    = hi_q;
    wait_d  = '0;
    unique case (state_q)
      gfxa_pkg::ST_OWN:
      begin
        // Request-line priority coding
        if (!shared_buffer_control_q)
        begin
          pend_d = 1'b0;
          gap_d  = 1'b0;
          hi_d   = 1'b0;
        end
        else if (req_act && gap_q)
        begin
          hi_d  = 1'b1;  // Gap closed: high priority
          gap_d = 1'b0;
        end
        else if (req_act)
          pend_d = 1'b1;
        else if (pend_q && !gap_q)
          gap_d = 1'b1;  // Maybe a priority pulse
        else if (gap_q)
        begin
          pend_d = 1'b0; // Withdrawn
          gap_d  = 1'b0;
          hi_d   = 1'b0;
        end
        if (hi_q && wait_q != gfxa_pkg::HI_BUDGET_CYC)
          wait_d = wait_q + 1'b1;
        else if (hi_q)
          wait_d = wait_q;
        // Release only while the line is asserted
        if (shared_buffer_control_q && req_act && !gap_q
            && ((hi_q && hi_ok) || lo_ok))
          state_d = gfxa_pkg::ST_FLOAT;
      end
      gfxa_pkg::ST_FLOAT:
        state_d = gfxa_pkg::ST_GRANT;  // Drivers off first
      gfxa_pkg::ST_GRANT:
      begin
        pend_d = 1'b0;
        gap_d  = 1'b0;
        hi_d   = 1'b0;
        if (!req_act)
          state_d = gfxa_pkg::ST_TAKE; // Reclaim after drop
      end
      gfxa_pkg::ST_TAKE:
        state_d = gfxa_pkg::ST_OWN;
      default:
        state_d = gfxa_pkg::ST_OWN;
    endcase
  end

  // Output next values; pin pair borrowed when enabled
  always_comb
  begin
    drive_d  = (state_d == gfxa_pkg::ST_OWN);  // Sole driver
    gnt_n_d  = pci_gnt_four_n;
    preq_n_d = req_s2_n;
    if (shared_buffer_control_q)
    begin
      gnt_n_d  = !(state_d == gfxa_pkg::ST_GRANT);
      preq_n_d = 1'b1;  // Hidden from the PCI arbiter
    end
    brk_d  = hi_d && burst_write_active;  // Line break
    disc_d = trdy_expired && pci_trdy_waiting;
  end

  // All state and outputs registered
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= gfxa_pkg::ST_OWN;
      pend_q  <= 1'b0;
      gap_q   <= 1'b0;
      hi_q    <= 1'b0;
      wait_q  <= '0;
      shared_buffer_control_q <= 1'b0;
      wlat_q  <= gfxa_pkg::WLAT_RST;
      rlat_q  <= gfxa_pkg::RLAT_RST;
      trdy_q  <= gfxa_pkg::TRDY_RST;
      ovr_q   <= 1'b0;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      gfx_mem_grant_n <= 1'b1;
      pci_req_four_n  <= 1'b1;
      dram_drive_en   <= 1'b1;
      burst_break     <= 1'b0;
      pci_disconnect  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      pend_q  <= pend_d;
      gap_q   <= gap_d;
      hi_q    <= hi_d;
      wait_q  <= wait_d;
      shared_buffer_control_q <= shared_buffer_control_d;
      wlat_q  <= wlat_d;
      rlat_q  <= rlat_d;
      trdy_q  <= trdy_d;
      ovr_q   <= ovr_d;
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
      gfx_mem_grant_n <= gnt_n_d;
      pci_req_four_n  <= preq_n_d;
      dram_drive_en   <= drive_d;
      burst_break     <= brk_d;
      pci_disconnect  <= disc_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_PARKED: assert property (
    state_q == gfxa_pkg::ST_OWN |-> dram_drive_en)
    else $error("device not driving while owner");

  AST_GRANT_FLOATED: assert property (
    (shared_buffer_control_q && $fell(gfx_mem_grant_n))
    |-> !dram_drive_en && !$past(dram_drive_en))
    else $error("grant given while drivers on");

  AST_RECLAIM: assert property (
    (state_q == gfxa_pkg::ST_GRANT && !req_act)
    |=> gfx_mem_grant_n ##1 dram_drive_en)
    else $error("bus not reclaimed after request drop");

  AST_LOWPRI: assert property (
    (state_q == gfxa_pkg::ST_OWN && !hi_q
     ##1 state_q == gfxa_pkg::ST_FLOAT)
    |-> $past(lo_ok))
    else $error("low priority granted while busy");

  AST_READ_RELEASE: assert property (
    (state_q == gfxa_pkg::ST_OWN && shared_buffer_control_q && hi_q
     && req_act && !gap_q && pci_read_active && prefetch_full)
    |=> state_q == gfxa_pkg::ST_FLOAT ##1 !gfx_mem_grant_n)
    else $error("read did not release on full prefetch");

  AST_WRITE_RELEASE: assert property (
    (state_q == gfxa_pkg::ST_OWN && shared_buffer_control_q && hi_q
     && req_act && !gap_q && pci_single_write_active
     && write_buf_empty)
    |=> state_q == gfxa_pkg::ST_FLOAT)
    else $error("write did not release on empty buffers");

  AST_BURST_BREAK: assert property (
    ($rose(hi_q) && $past(burst_write_active)) |-> burst_break)
    else $error("burst not broken at high priority");

  AST_TIMER_START: assert property (
    (lat_run && !lat_load) |=> lat_running || lat_load)
    else $error("latency timer did not start");

  AST_PIN_SHARE: assert property (
    !shared_buffer_control_q |=> gfx_mem_grant_n == $past(pci_gnt_four_n))
    else $error("pin pair not returned to PCI");

endmodule

//--- hw/gfxa_pkg.sv
// Constants, register map and state codes of the shared memory arbiter.
// Assumes one 100 MHz clock; nothing is imported, users write gfxa_pkg::.
package gfxa_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;

  // Control fields
  localparam int SET_W        = 3;   // Width of every timer setting
  localparam int CTRL_EN_BIT  = 0;   // Shared buffer enable
  localparam int CTRL_WLAT_LO = 4;   // Latency setting for writes
  localparam int CTRL_RLAT_LO = 8;   // Latency setting for reads
  localparam int CTRL_TRDY_LO = 12;  // Target-ready delay setting

  // Status fields
  localparam int STAT_GNT_BIT = 0;   // Bus granted to graphics
  localparam int STAT_HI_BIT  = 1;   // High-priority request pending
  localparam int STAT_RUN_BIT = 2;   // Latency timer running
  localparam int STAT_OVR_BIT = 3;   // Sticky latency overrun, W1C

  // Reset values of the settings (times four host clocks)
  localparam logic [SET_W-1:0] WLAT_RST = 3'h3;  // 12 clocks
  localparam logic [SET_W-1:0] RLAT_RST = 3'h4;  // 16 clocks
  localparam logic [SET_W-1:0] TRDY_RST = 3'h4;  // 16 clocks

  // Timer counters: setting shifted left by two, 0..28
  localparam int CNT_W      = 5;
  localparam int STEP_SHIFT = 2;

  // High-priority latency budget
  localparam int CLK_PERIOD_NS = 10;
  localparam int HI_BUDGET_NS  = 400;
  localparam int WAIT_W        = 8;
  localparam logic [WAIT_W-1:0] HI_BUDGET_CYC =
    WAIT_W'(HI_BUDGET_NS / CLK_PERIOD_NS);

  // Arbiter states, one-hot
  typedef enum logic [3:0] {
    ST_OWN   = 4'b0001,  // Device owns and drives DRAM
    ST_FLOAT = 4'b0010,  // Drivers off, grant not yet out
    ST_GRANT = 4'b0100,  // Graphics owns DRAM
    ST_TAKE  = 4'b1000   // Request gone, grant withdrawn
  } gfxa_state_t;

endpackage

//--- hw/gfxa_timer.sv
// Down-counting timer used for the latency and target-ready limits.
// Assumes load and run come from logic on the same clock.
`timescale 1ns/1ps
module gfxa_timer
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        load,
  input  wire logic                        run,
  input  wire logic [gfxa_pkg::SET_W-1:0]  setting,
  output logic                             expired,
  output logic                             running
);

  logic [gfxa_pkg::CNT_W-1:0] count_q;  // Remaining clocks
  logic [gfxa_pkg::CNT_W-1:0] count_d;
  logic                       run_q;    // Counting since start
  logic                       run_d;
  logic [gfxa_pkg::CNT_W-1:0] preset;   // Setting times four

  // Setting in steps of four clocks
  assign preset  =
    gfxa_pkg::CNT_W'({setting, {gfxa_pkg::STEP_SHIFT{1'b0}}});
  assign expired = run_q && (count_q == '0);
  assign running = run_q;

  // Next count; load wins so a stop is never missed
  always_comb
  begin
    count_d = count_q;
    run_d   = run_q;
    if (load)
    begin
      count_d = preset;  // Reload and stop
      run_d   = 1'b0;
    end
    else if (run || run_q)
    begin
      run_d = 1'b1;      // Once started it runs on, holding at zero
      if (run_q && count_q != '0)
        count_d = count_q - 1'b1;
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= '0;
      run_q   <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      run_q   <= run_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TMR_PRESET: assert property (
    load |=> count_q == $past(preset) && !run_q)
    else $error("timer did not take the preset");

  AST_TMR_STEP: assert property (
    (run_q && !load && count_q != '0) |=> count_q == $past(count_q) - 1'b1)
    else $error("timer did not count down by one");

endmodule

//--- bench/gfxa_gfx_model.sv
// Graphics agent model: drives the memory request pin of the arbiter.
// Assumes the shared pclk; the request pin idles high (pulled up).
`timescale 1ns/1ps
module gfxa_gfx_model
(
  input  wire logic pclk,
  input  wire logic gfx_mem_grant_n,
  output logic      gfx_mem_request_n
);
  int hold = 3;  // Clocks of ownership before giving back
  int held = 0;  // Clocks owned so far

  initial gfx_mem_request_n = 1'b1;

  // Low priority is a plain low level, changed after an edge
  task req_low();
    @(posedge pclk);
    gfx_mem_request_n <= 1'b0;
  endtask

  // Withdraw the request line
  task req_off();
    @(posedge pclk);
    gfx_mem_request_n <= 1'b1;
  endtask

  // High priority: low, high for exactly one clock, low again
  task req_high();
    req_low();
    repeat (3) @(posedge pclk);
    gfx_mem_request_n <= 1'b1;
    @(posedge pclk);
    gfx_mem_request_n <= 1'b0;
  endtask

  // Owner drops its request once done, so the device may reclaim
  always @(posedge pclk)
  begin
    if (gfx_mem_grant_n === 1'b0)
      held <= held + 1;
    else
      held <= 0;
    if (gfx_mem_grant_n === 1'b0 && held == hold)
      gfx_mem_request_n <= 1'b1;
  end
endmodule

//--- bench/gfxa_arbiter_bench.sv
// Self-checking bench of the shared memory arbiter.
// Assumes the graphics agent model beside it; expectations come from a
// mirror of the control register kept in ctrl_m.
`timescale 1ns/1ps
module gfxa_arbiter_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, grant_n, req4_n, drv_en, brk, disc, req_n;
  logic        gnt4_n = 1'b1;  // Internal PCI arbiter grant
  logic [2:0]  pend = 3'h0;    // Cpu, pci, refresh pending
  logic [7:0]  tr = 8'h00;     // Memory traffic status bits
  logic        trdy_w = 1'b0;  // PCI waiting on target ready
  logic [31:0] rd;             // Last read data
  logic        er;             // Last error response
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          seed = 27078;
  int          ctrl_m = 'h4430; // Mirror of the control register
  int          t;
  int          dly;             // Clocks until disconnect seen

  gfxa_arbiter dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gfx_mem_request_n(req_n), .gfx_mem_grant_n(grant_n),
    .pci_req_four_n(req4_n), .pci_gnt_four_n(gnt4_n),
    .cpu_req_pending(pend[0]), .pci_req_pending(pend[1]),
    .refresh_hi_pending(pend[2]), .dram_busy(tr[0]),
    .pci_read_active(tr[1]), .pci_single_write_active(tr[2]),
    .cpu_single_write_active(tr[3]), .burst_write_active(tr[4]),
    .prefetch_full(tr[5]), .write_buf_empty(tr[6]),
    .write_cycle_done(tr[7]), .pci_trdy_waiting(trdy_w),
    .dram_drive_en(drv_en), .burst_break(brk), .pci_disconnect(disc));

  gfxa_gfx_model model (.pclk(pclk), .gfx_mem_grant_n(grant_n),
    .gfx_mem_request_n(req_n));

  // 100 MHz clock
  always #5 pclk = ~pclk;

  task give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, well above the several hundred clocks the tests need
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    cmp_count++;
    if (s !== e)
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, s, e);
    if (s !== e)
      n_errors++;
  endtask

  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cap on this wait; if pready never rises, the hang guard ends it
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w && a == gfxa_pkg::CTRL_OFS)
      ctrl_m = d & 'h7771;
  endtask

  // Waits for the grant, checks its window, then the reclaim
  task wait_grant(input int lo, input int hi, input string m);
    int n;
    n = 0;
    while (grant_n !== 1'b0 && n <= hi)
    begin
      @(posedge pclk);
      n++;
    end
    chk(n >= lo && n <= hi, 1, m);
    chk(drv_en, 1'b0, "drivers off while granted");
    n = 0;
    while (grant_n !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    repeat (3) @(posedge pclk);
    chk(drv_en, 1'b1, "device parked again");
    tr <= 8'h00;
  endtask

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk(grant_n, 1'b1, "reset grant");
    chk(drv_en, 1'b1, "reset drive");
    apb(1'b0, gfxa_pkg::CTRL_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_4430, "ctrl reset");
    apb(1'b0, gfxa_pkg::STAT_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "stat reset");
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped read");
    chk(er, 1'b1, "unmapped error");
    $display("test reset done");
    // Disabled: request passes to the PCI arbiter pair
    model.hold = 100;
    model.req_low();
    repeat (5) @(posedge pclk);
    chk(req4_n, 1'b0, "pci pair request");
    gnt4_n <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(grant_n, 1'b0, "pci pair grant");
    gnt4_n <= 1'b1;
    model.req_off();
    repeat (3) @(posedge pclk);
    chk(grant_n, 1'b1, "pci pair idle");
    $display("test disabled done");
    // Random settings, read back through the mirror
    t = $random(seed);
    apb(1'b1, gfxa_pkg::CTRL_OFS, t | 1);
    apb(1'b0, gfxa_pkg::CTRL_OFS, 32'h0000_0000);
    chk(rd, ctrl_m, "ctrl readback");
    t = ((ctrl_m >> 12) & 7) * 4;
    dly = 0;
    @(posedge pclk);
    trdy_w <= 1'b1;
    // Count clocks until the disconnect shows, capped
    while (disc !== 1'b1 && dly < 40)
    begin
      @(posedge pclk);
      dly++;
    end
    chk(dly >= t && dly <= t + 4, 1, "disconnect delay");
    trdy_w <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(disc, 1'b0, "disconnect ends");
    $display("test target ready done");
    // Low priority waits for every kind of pending request
    model.hold = 3;
    apb(1'b1, gfxa_pkg::CTRL_OFS, 32'h0000_4431);
    for (int k = 0; k < 3; k++)
    begin
      pend <= 3'h1 << k;
      model.req_low();
      repeat (15) @(posedge pclk);
      chk(grant_n, 1'b1, "low held off");
      pend <= 3'h0;
      wait_grant(0, 10, "low grant");
    end
    $display("test low priority done");
    // High priority on a read, every timer setting
    for (int s = 0; s < 8; s++)
    begin
      apb(1'b1, gfxa_pkg::CTRL_OFS, 32'h0000_4031 | (s << 8));
      t = ((ctrl_m >> 8) & 7) * 4;
      tr <= 8'h03;
      model.req_high();
      wait_grant(t, t + 12, "read timer");
    end
    tr <= 8'h23;
    model.req_high();
    wait_grant(0, 12, "prefetch full");
    $display("test reads done");
    apb(1'b1, gfxa_pkg::CTRL_OFS, 32'h0000_4431);
    tr <= ($random(seed) & 1) ? 8'h89 : 8'h85;
    model.req_high();
    wait_grant(12, 24, "write timer");
    tr <= 8'h45;
    model.req_high();
    wait_grant(0, 12, "write buffers empty");
    tr <= 8'h11;
    model.req_high();
    repeat (8) @(posedge pclk);
    chk(brk, 1'b1, "burst break");
    chk(grant_n, 1'b1, "burst still owned");
    apb(1'b0, gfxa_pkg::STAT_OFS, 32'h0000_0000);
    chk(rd, 32'h0000_0002, "stat high pending");
    tr <= 8'h00;
    wait_grant(0, 12, "burst grant");
    // A pending cpu request keeps the low path shut, so only the
    // high-priority pulse can win the bus here
    pend <= 3'h1;
    model.req_high();
    wait_grant(0, 35, "idle high grant");
    pend <= 3'h0;
    $display("test high priority done");
    give_verdict();
  end
endmodule
